//--- verilog/adcm_params.svh
// Constants for the converter mode control block.
// Assumes inclusion by bare name from the package; the design module uses its macros without including it.
`ifndef ADCM_PARAMS_SVH
`define ADCM_PARAMS_SVH
`define ADCM_MODE_ADDR       8'hD8
`define ADCM_MODE_RESET      8'h00
`define ADCM_BIT_DONE        7
`define ADCM_BIT_DMA         6
`define ADCM_BIT_CONT        5
`define ADCM_BIT_SINGLE      4
`define ADCM_CONV_CLOCKS     17
`define ADCM_DIV_LIMIT_8     5'h07
`define ADCM_DIV_LIMIT_4     5'h03
`define ADCM_DIV_LIMIT_16    5'h0F
`define ADCM_DIV_LIMIT_32    5'h1F
`define ADCM_CLK_MHZ         20
`endif

//--- verilog/adcm_pkg.sv
// Types for the converter mode control block.
// Assumes adcm_params.svh on the include path.
`include "adcm_params.svh"
package adcm_pkg;
  typedef enum logic [1:0] {
    ADCM_IDLE = 2'b00,
    ADCM_CONV = 2'b01,
    ADCM_DMA  = 2'b10
  } adcm_state_t;
endpackage : adcm_pkg

//--- verilog/adcm_mode_ctrl.sv
// Converter mode control register and conversion sequencer.
// Assumes an 8051-style SFR bus on clk, and a DMA engine reporting done.
// Functional notes
// - Conversion-done flag bit 7 sets at the end of every single or continuous conversion, not when a DMA capture finishes.
// - The flag clears itself when the core vectors to the converter interrupt.
// - Writing one to bit 6 starts the preconfigured DMA capture, set up beforehand.
// - The DMA enable bit returns to zero when the DMA capture finishes.
// - The address latch strobe is held off while DMA mode is enabled.
// - Bit 5 puts the converter into free-running conversion.
// - Continuous conversions use the channel and timing already programmed.
// - In continuous mode a new conversion starts as soon as the last completes.
// - Writing one to bit 4 launches exactly one conversion.
// - Bit 4 clears itself when its single conversion completes.
// - The register sits at SFR D8H, resets to 00H and is bit addressable.
// - Low nibble selects the channel at start, except DMA takes the channel from memory.
// - A conversion takes seventeen converter clocks from a divided master clock.
`timescale 1ns/1ns
module adcm_mode_ctrl
  import adcm_pkg::*;
#(
  parameter int CONV_CLOCKS = `ADCM_CONV_CLOCKS
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // SFR bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       bit_wr,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  output logic      [7:0] sfr_rdata,
  // Interrupt handshake
  input  wire logic       int_enable,
  input  wire logic       int_vector_ack,
  output logic            int_request,
  // Converter clock and DMA engine
  input  wire logic [1:0] clk_div_sel,
  input  wire logic [3:0] dma_channel,
  input  wire logic       dma_done,
  output logic            conv_start,
  output logic      [3:0] conv_channel,
  output logic            conv_busy,
  // Address latch strobe
  input  wire logic       ale_core,
  output logic            ale_out
);

  logic [7:0]  mode_reg;
  adcm_state_t state;
  logic [4:0]  div_cnt;
  logic        adc_tick;
  logic [5:0]  conv_cnt;
  logic        conv_end;
  logic        reg_hit;
  logic [7:0]  wr_value;
  logic [4:0]  div_limit;

  assign reg_hit = (sfr_addr == `ADCM_MODE_ADDR);

  // Byte write or single-bit write to the same register
  always_comb begin
    wr_value = mode_reg;
    if (sfr_wr && reg_hit) begin
      wr_value = sfr_wdata;
    end else if (bit_wr && reg_hit) begin
      wr_value[bit_sel] = bit_val;
    end
  end

  // Converter clock divider: 8, 4, 16 or 32 master clocks
  always_comb begin
    case (clk_div_sel)
      2'b00:   div_limit = `ADCM_DIV_LIMIT_8;
      2'b01:   div_limit = `ADCM_DIV_LIMIT_4;
      2'b10:   div_limit = `ADCM_DIV_LIMIT_16;
      default: div_limit = `ADCM_DIV_LIMIT_32;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt  <= 5'h00;
      adc_tick <= 1'b0;
    end else begin
      adc_tick <= (div_cnt >= div_limit);
      div_cnt  <= (div_cnt >= div_limit) ? 5'h00 : div_cnt + 5'h01;
    end
  end

  assign conv_end = (state == ADCM_CONV) && adc_tick &&
                    (conv_cnt == 6'(CONV_CLOCKS - 1));

  // Sequencer: idle, converting, DMA capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= ADCM_IDLE;
      conv_cnt     <= 6'h00;
      conv_start   <= 1'b0;
      conv_channel <= 4'h0;
    end else begin
      conv_start <= 1'b0;
      case (state)
        ADCM_IDLE: begin
          if (mode_reg[`ADCM_BIT_DMA]) begin
            state        <= ADCM_DMA;
            conv_channel <= dma_channel;
          end else if (mode_reg[`ADCM_BIT_SINGLE] || mode_reg[`ADCM_BIT_CONT]) begin
            state        <= ADCM_CONV;
            conv_cnt     <= 6'h00;
            conv_start   <= 1'b1;
            conv_channel <= mode_reg[3:0];
          end
        end
        ADCM_CONV: begin
          if (adc_tick) begin
            conv_cnt <= conv_cnt + 6'h01;
          end
          if (conv_end) begin
            if (mode_reg[`ADCM_BIT_CONT]) begin
              conv_cnt     <= 6'h00;
              conv_start   <= 1'b1;
              conv_channel <= mode_reg[3:0];
            end else begin
              state <= ADCM_IDLE;
            end
          end
        end
        ADCM_DMA: begin
          conv_channel <= dma_channel;
          if (dma_done) begin
            state <= ADCM_IDLE;
          end
        end
        default: state <= ADCM_IDLE;
      endcase
    end
  end

  // Register: hardware sets win over software clears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= `ADCM_MODE_RESET;
    end else begin
      mode_reg <= wr_value;
      if (int_vector_ack) begin
        mode_reg[`ADCM_BIT_DONE] <= 1'b0;
      end
      if (conv_end && !mode_reg[`ADCM_BIT_CONT]) begin
        mode_reg[`ADCM_BIT_SINGLE] <= 1'b0;
      end
      if (state == ADCM_DMA && dma_done) begin
        mode_reg[`ADCM_BIT_DMA] <= 1'b0;
      end
      if (conv_end) begin
        mode_reg[`ADCM_BIT_DONE] <= 1'b1;
      end
    end
  end

  // Outputs registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata   <= 8'h00;
      int_request <= 1'b0;
      ale_out     <= 1'b0;
      conv_busy   <= 1'b0;
    end else begin
      sfr_rdata   <= reg_hit ? mode_reg : 8'h00;
      int_request <= mode_reg[`ADCM_BIT_DONE] && int_enable;
      ale_out     <= ale_core && !mode_reg[`ADCM_BIT_DMA];
      conv_busy   <= (state != ADCM_IDLE);
    end
  end

  property p_done_set;
    @(posedge clk) disable iff (reset)
      conv_end |=> mode_reg[`ADCM_BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_clear;
    @(posedge clk) disable iff (reset)
      (int_vector_ack && !conv_end) |=> !mode_reg[`ADCM_BIT_DONE];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_dma_clear;
    @(posedge clk) disable iff (reset)
      (state == ADCM_DMA && dma_done) |=> !mode_reg[`ADCM_BIT_DMA];
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("dma bit stuck");

  property p_ale_off;
    @(posedge clk) disable iff (reset)
      mode_reg[`ADCM_BIT_DMA] |=> !ale_out;
  endproperty
  a_ale_off: assert property (p_ale_off) else $error("strobe during dma");

  property p_cont_restart;
    @(posedge clk) disable iff (reset)
      (conv_end && mode_reg[`ADCM_BIT_CONT]) |=> conv_start && state == ADCM_CONV;
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("no restart");

  property p_single_clear;
    @(posedge clk) disable iff (reset)
      (conv_end && !mode_reg[`ADCM_BIT_CONT]) |=>
        !mode_reg[`ADCM_BIT_SINGLE] && state == ADCM_IDLE;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("single bit stuck");

  property p_single_start;
    @(posedge clk) disable iff (reset)
      (state == ADCM_IDLE && mode_reg[`ADCM_BIT_SINGLE] && !mode_reg[`ADCM_BIT_DMA])
        |=> conv_start && conv_channel == $past(mode_reg[3:0]);
  endproperty
  a_single_start: assert property (p_single_start) else $error("no start");

  property p_irq;
    @(posedge clk) disable iff (reset)
      (mode_reg[`ADCM_BIT_DONE] && int_enable) |=> int_request;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt request");

endmodule : adcm_mode_ctrl

//--- bench/adcm_core_model.sv
// Stand-in for the core interrupt logic and the DMA engine.
// Assumes ale_core is held high, so a low ale_out marks DMA in progress.
`timescale 1ns/1ns
module adcm_core_model #(
  parameter int DMA_LEN = 12
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Device side
  input  wire logic int_request,
  input  wire logic ale_out,
  input  wire logic ack_en,
  output logic      int_vector_ack,
  output logic      dma_done
);
  int dma_cnt;
  // Vectors only when the bench lets it, so polling can be tested too
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      int_vector_ack <= 1'b0;
    else
      int_vector_ack <= ack_en && int_request && !int_vector_ack;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dma_cnt  <= 0;
      dma_done <= 1'b0;
    end else begin
      dma_done <= (dma_cnt == DMA_LEN);
      dma_cnt  <= ale_out ? 0 : dma_cnt + 1;
    end
  end
endmodule : adcm_core_model

//--- bench/adc_conversion_mode_control_tb_top.sv
// Self-checking bench for the converter mode control block.
// Assumes the core model stands in for the interrupt logic and DMA engine.
`timescale 1ns/1ns
module adc_conversion_mode_control_tb_top;
  localparam int CONV = 3;
  logic       clk = 0, reset = 1, sfr_wr = 0, bit_wr = 0, bit_val = 0;
  logic       int_enable = 0, ack_en = 0;
  logic [7:0] sfr_addr = 8'hD8, sfr_wdata = 8'h00, sfr_rdata, v;
  logic [2:0] bit_sel = 3'h0;
  logic [1:0] clk_div_sel = 2'b00;
  int         cyc = 0;
  logic       int_vector_ack, int_request, dma_done, conv_start, conv_busy, ale_out;
  logic [3:0] conv_channel;
  int         errors = 0, tests_run = 0, starts = 0, acks = 0;
  // Write address, write data, read address, expected read
  logic [7:0] rows [4][4] = '{'{8'hD8, 8'h03, 8'hD8, 8'h03}, '{8'hD8, 8'h0F, 8'hD8, 8'h0F},
                              '{8'hD9, 8'h0C, 8'hD8, 8'h0F}, '{8'hD8, 8'h00, 8'hD9, 8'h00}};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (conv_start === 1'b1) starts++;
    if (int_vector_ack === 1'b1) acks++;
  end
  adcm_mode_ctrl #(.CONV_CLOCKS(CONV)) adcm_mode_ctrl_i (.clk(clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .bit_wr(bit_wr),
    .bit_sel(bit_sel), .bit_val(bit_val), .sfr_rdata(sfr_rdata), .int_enable(int_enable),
    .int_vector_ack(int_vector_ack), .int_request(int_request), .clk_div_sel(clk_div_sel),
    .dma_channel(4'hA), .dma_done(dma_done), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_busy(conv_busy), .ale_core(1'b1), .ale_out(ale_out));
  adcm_core_model adcm_core_model_i (.clk(clk), .reset(reset), .int_request(int_request),
    .ale_out(ale_out), .ack_en(ack_en), .int_vector_ack(int_vector_ack), .dma_done(dma_done));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] d, logic bitw = 0);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    bit_sel = d[2:0];
    bit_val = d[3];
    sfr_wr = !bitw;
    bit_wr = bitw;
    @(negedge clk);
    sfr_wr = 0;
    bit_wr = 0;
    sfr_addr = 8'hD8;
  endtask : wr
  task automatic rd(logic [7:0] a);
    sfr_addr = a;
    @(negedge clk);
    v = sfr_rdata;
  endtask : rd
  task automatic wait_bit(string name, int idx, logic val);
    int n = 0;
    sfr_addr = 8'hD8;
    while (sfr_rdata[idx] !== val && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(name, {7'h0, sfr_rdata[idx]}, {7'h0, val});
  endtask : wait_bit
  // Selector instead of a ref argument: 0 watches conv_start, 1 watches conv_busy
  task automatic wait_sig(int which, logic val);
    int n = 0;
    while ((which == 0 ? conv_start : conv_busy) !== val && n < 400) begin
      @(negedge clk);
      n++;
    end
    if ((which == 0 ? conv_start : conv_busy) !== val) begin
      errors++;
      $display("BAD wait %0d expected %h seen timeout", which, val);
    end
  endtask : wait_sig
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #(50 * 20000);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    reset = 0;
    rd(8'hD8);
    check("reset value", v, 8'h00);
    check("idle outputs", {conv_start, conv_busy, int_request, ale_out, 4'h0}, 8'h10);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][2]);
      check("row readback", v, rows[i][3]);
    end
    wr(8'hD8, 8'h0A, 1);
    rd(8'hD8);
    check("bit write", v, 8'h04);
    $display("Register tests done");
    wr(8'hD8, 8'h15);
    starts = 0;
    wait_sig(0, 1'b1);
    check("single channel", {4'h0, conv_channel}, 8'h05);
    wait_bit("done flag", 7, 1'b1);
    wait_bit("single clears", 4, 1'b0);
    check("one start", starts[7:0], 8'h01);
    check("no request", {7'h0, int_request}, 8'h00);
    wr(8'hD8, 8'h07, 1);
    rd(8'hD8);
    check("flag cleared by code", v, 8'h05);
    $display("Single test done");
    clk_div_sel = 2'b11;
    wr(8'hD8, 8'h13);
    wait_sig(0, 1'b1);
    cyc = 0;
    while (sfr_rdata[7] !== 1'b1 && cyc < 400) begin
      @(negedge clk);
      cyc++;
    end
    // Free-running divider: the first tick lands anywhere in one period
    v = {7'h0, cyc >= (CONV - 1) * 32 + 2 && cyc <= CONV * 32 + 1};
    check("divide by 32 length", v, 8'h01);
    wr(8'hD8, 8'h07, 1);
    clk_div_sel = 2'b00;
    $display("Divider test done");
    int_enable = 1;
    ack_en = 1;
    starts = 0;
    acks = 0;
    wr(8'hD8, 8'h22);
    repeat (30 * CONV + 20) @(negedge clk);
    check("auto restarts", {7'h0, starts >= 3}, 8'h01);
    check("cont channel", {4'h0, conv_channel}, 8'h02);
    check("vector ack seen", {7'h0, acks > 0}, 8'h01);
    wr(8'hD8, 8'h00);
    wait_sig(1, 1'b0);
    int_enable = 0;
    wait_bit("flag cleared by vector", 7, 1'b0);
    $display("Continuous test done");
    wr(8'hD8, 8'h40);
    @(negedge clk);
    check("strobe halted", {7'h0, ale_out}, 8'h00);
    check("dma bit set", {7'h0, sfr_rdata[6]}, 8'h01);
    check("dma channel", {4'h0, conv_channel}, 8'h0A);
    wait_bit("dma clears", 6, 1'b0);
    repeat (2) @(negedge clk);
    check("strobe resumes", {7'h0, ale_out}, 8'h01);
    $display("DMA test done");
    wr(8'hD8, 8'h25);
    wait_sig(1, 1'b1);
    reset = 1;
    @(negedge clk);
    v = {conv_start, conv_busy, int_request, ale_out, sfr_rdata[3:0]};
    check("held in reset", v, 8'h00);
    repeat (2) @(negedge clk);
    reset = 0;
    rd(8'hD8);
    check("reset mid-run", v, 8'h00);
    check("idle after reset", {conv_start, conv_busy, int_request, ale_out, 4'h0}, 8'h10);
    $display("Reset test done");
    end_of_test();
  end
endmodule : adc_conversion_mode_control_tb_top
